// >>> rtl/eightb_tenb_lut_codec.sv
// package of codec constants and the table-driven 8b/10b codec top module
// Behaviour
// - Each input byte becomes exactly one 10-bit symbol and each received symbol one byte.
// - The low five bits of the byte are looked up in the five-to-six table.
// - The high three bits of the byte are looked up in the three-to-four table.
// - The six- and four-bit groups join into one symbol, and decoding undoes both lookups.
// - Ones and zeros balance only per group; one fixed variant leaves the stream's disparity untracked.
// - Runs of equal bits are not bounded across groups; byte 8'he0 gives six zeros in a row.
// - All four lookup tables are loaded before any encoding or decoding happens.
// - Encode word: raw five bits in byte 0, raw three in byte 1, six-bit in 3, four-bit in 2.
// - Decode word: six-bit group in byte 1 gives byte 2, four-bit group in byte 0 gives byte 3.
// - The decoded byte is byte 3 shifted left five plus byte 2, placed in byte 0.
// - Encode tables take the binary value and give code bit a, sent first, as the group MSB; decode tables the reverse.
package codec_pkg;
  localparam int          LO_W         = 5;
  localparam int          HI_W         = 3;
  localparam int          SIX_W        = 6;
  localparam int          FOUR_W       = 4;
  localparam int          SYM_W        = 10;
  localparam int          ENT_W        = 8;
  localparam int          ADDR_W       = 6;
  localparam int          SEL_W        = 2;
  localparam int          HI_SHIFT     = 5;
  // byte lanes of the working words
  localparam int          B0           = 0;
  localparam int          B1           = 8;
  localparam int          B2           = 16;
  localparam int          B3           = 24;
  localparam logic [7:0]  invalid_code_marker = 8'hff;
  localparam logic [1:0]  SEL_ENC6     = 2'h0;
  localparam logic [1:0]  SEL_ENC4     = 2'h1;
  localparam logic [1:0]  SEL_DEC5     = 2'h2;
  localparam logic [1:0]  SEL_DEC3     = 2'h3;
  // one fixed disparity variant, bit a (first on the line) is the group msb
  localparam logic [5:0] ENC6_CODE [32] = '{
    6'h18, 6'h22, 6'h12, 6'h31, 6'h0a, 6'h29, 6'h19, 6'h07,
    6'h06, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h28,
    6'h24, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h05,
    6'h0c, 6'h26, 6'h16, 6'h09, 6'h0e, 6'h11, 6'h21, 6'h14};
  localparam logic [3:0] ENC4_CODE [8] = '{
    4'h4, 4'h9, 4'h5, 4'h3, 4'h2, 4'ha, 4'h6, 4'h1};
  localparam int          D7_LO        = 7;
  localparam int          D3_HI        = 3;

  function automatic int ones(input logic [5:0] v);
    int n;
    n = 0;
    for (int i = 0; i < SIX_W; i++) begin
      n = n + int'(v[i]);
    end
    return n;
  endfunction : ones

  function automatic logic [32*ENT_W-1:0] enc6_init();
    logic [32*ENT_W-1:0] r;
    r = '0;
    for (int v = 0; v < 32; v++) begin
      r[v*ENT_W +: ENT_W] = {2'h0, ENC6_CODE[v]};
    end
    return r;
  endfunction : enc6_init

  function automatic logic [8*ENT_W-1:0] enc4_init();
    logic [8*ENT_W-1:0] r;
    r = '0;
    for (int v = 0; v < 8; v++) begin
      r[v*ENT_W +: ENT_W] = {4'h0, ENC4_CODE[v]};
    end
    return r;
  endfunction : enc4_init

  // received groups of the opposite disparity decode too; balanced ones are unique except value 7, whose complement decodes too
  function automatic logic [64*ENT_W-1:0] dec5_init();
    logic [64*ENT_W-1:0] r;
    logic [5:0]          c;
    logic [5:0]          cc;
    for (int i = 0; i < 64; i++) begin
      r[i*ENT_W +: ENT_W] = invalid_code_marker;
    end
    for (int v = 0; v < 32; v++) begin
      c  = ENC6_CODE[v];
      // complement held at group width, an inline cast would widen it first
      cc = ~c;
      r[int'(c)*ENT_W +: ENT_W] = 8'(v);
      if (ones(c) != SIX_W / 2 || v == D7_LO) begin
        r[int'(cc)*ENT_W +: ENT_W] = 8'(v);
      end
    end
    return r;
  endfunction : dec5_init

  function automatic logic [16*ENT_W-1:0] dec3_init();
    logic [16*ENT_W-1:0] r;
    logic [3:0]          c;
    logic [3:0]          cc;
    for (int i = 0; i < 16; i++) begin
      r[i*ENT_W +: ENT_W] = invalid_code_marker;
    end
    for (int v = 0; v < 8; v++) begin
      c  = ENC4_CODE[v];
      cc = ~c;
      r[int'(c)*ENT_W +: ENT_W] = 8'(v);
      if (ones({2'h0, c}) != FOUR_W / 2 || v == D3_HI) begin
        r[int'(cc)*ENT_W +: ENT_W] = 8'(v);
      end
    end
    return r;
  endfunction : dec3_init

  typedef enum logic [1:0] {
    DEC_IDLE = 2'h0,
    DEC_LOOK = 2'h1,
    DEC_COMB = 2'h3
  } dec_state_t;
endpackage : codec_pkg

`timescale 1ns/1ps
module eightb_tenb_lut_codec (
  input  wire logic                          ref_clk,       // core clock, 125 MHz
  input  wire logic                          rst,           // synchronous reset, active high
  input  wire logic                          tbl_wr,        // table entry write strobe
  input  wire logic [codec_pkg::SEL_W-1:0]   tbl_sel,       // which of the four tables
  input  wire logic [codec_pkg::ADDR_W-1:0]  tbl_addr,      // entry index
  input  wire logic [codec_pkg::ENT_W-1:0]   tbl_data,      // entry value
  input  wire logic                          enc_in_valid,  // byte offered for encoding
  output logic                               enc_in_ready,  // encoder takes the byte
  input  wire logic [7:0]                    enc_byte,      // byte to encode
  output logic                               enc_out_valid, // symbol pulse
  output logic [codec_pkg::SYM_W-1:0]        enc_sym,       // symbol, bit 9 sent first
  input  wire logic                          dec_in_valid,  // symbol offered for decoding
  output logic                               dec_in_ready,  // decoder takes the symbol
  input  wire logic [codec_pkg::SYM_W-1:0]   dec_sym,       // received symbol, bit 9 first
  output logic                               dec_out_valid, // byte pulse
  output logic [7:0]                         dec_byte,      // decoded byte
  output logic                               dec_err        // code error with dec_out_valid
);
  import codec_pkg::*;

  typedef struct packed {
    logic [31:0] enc_word;
    logic        enc_out_valid;
    logic [31:0] dec_word;
    dec_state_t  dstate;
    logic        dec_out_valid;
    logic        dec_err;
  } core_t;

  core_t             st;
  core_t             next_st;
  logic [ENT_W-1:0]  enc6_q;
  logic [ENT_W-1:0]  enc4_q;
  logic [ENT_W-1:0]  dec5_q;
  logic [ENT_W-1:0]  dec3_q;
  logic              enc_take;
  logic              dec_take;

  // tables come out of reset holding the standard groups, so they are loaded
  // before the first request; software may rewrite them while traffic is idle
  lut_table #(.ADDR_W(LO_W), .DATA_W(ENT_W), .INIT(enc6_init())) u_enc6 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (tbl_wr && tbl_sel == SEL_ENC6),
    .wr_addr (tbl_addr[LO_W-1:0]),
    .wr_data (tbl_data),
    .rd_addr (enc_byte[LO_W-1:0]),
    .rd_data (enc6_q)
  );
  lut_table #(.ADDR_W(HI_W), .DATA_W(ENT_W), .INIT(enc4_init())) u_enc4 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (tbl_wr && tbl_sel == SEL_ENC4),
    .wr_addr (tbl_addr[HI_W-1:0]),
    .wr_data (tbl_data),
    .rd_addr (enc_byte[7:LO_W]),
    .rd_data (enc4_q)
  );
  lut_table #(.ADDR_W(SIX_W), .DATA_W(ENT_W), .INIT(dec5_init())) u_dec5 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (tbl_wr && tbl_sel == SEL_DEC5),
    .wr_addr (tbl_addr),
    .wr_data (tbl_data),
    .rd_addr (st.dec_word[B1 +: SIX_W]),
    .rd_data (dec5_q)
  );
  lut_table #(.ADDR_W(FOUR_W), .DATA_W(ENT_W), .INIT(dec3_init())) u_dec3 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .wr_en   (tbl_wr && tbl_sel == SEL_DEC3),
    .wr_addr (tbl_addr[FOUR_W-1:0]),
    .wr_data (tbl_data),
    .rd_addr (st.dec_word[B0 +: FOUR_W]),
    .rd_data (dec3_q)
  );

  // a table write in flight stalls both directions for that cycle
  assign enc_in_ready = !tbl_wr;
  assign dec_in_ready = !tbl_wr && st.dstate == DEC_IDLE;
  assign enc_take     = enc_in_valid && enc_in_ready;
  assign dec_take     = dec_in_valid && dec_in_ready;

  always_comb begin
    next_st               = st;
    next_st.enc_out_valid = 1'b0;
    next_st.dec_out_valid = 1'b0;
    if (enc_take) begin
      next_st.enc_word[B0 +: 8] = {3'h0, enc_byte[LO_W-1:0]};
      next_st.enc_word[B1 +: 8] = {5'h0, enc_byte[7:LO_W]};
      next_st.enc_word[B3 +: 8] = {2'h0, enc6_q[SIX_W-1:0]};
      next_st.enc_word[B2 +: 8] = {4'h0, enc4_q[FOUR_W-1:0]};
      next_st.enc_out_valid     = 1'b1;
    end
    case (st.dstate)
      DEC_IDLE: begin
        if (dec_take) begin
          next_st.dec_word[B1 +: 8] = {2'h0, dec_sym[SYM_W-1:FOUR_W]};
          next_st.dec_word[B0 +: 8] = {4'h0, dec_sym[FOUR_W-1:0]};
          next_st.dstate            = DEC_LOOK;
        end
      end
      DEC_LOOK: begin
        next_st.dec_word[B2 +: 8] = dec5_q;
        next_st.dec_word[B3 +: 8] = dec3_q;
        next_st.dstate            = DEC_COMB;
      end
      DEC_COMB: begin
        // on error the marker bits leak into the byte; dec_err says to drop it
        next_st.dec_word[B0 +: 8] = 8'(st.dec_word[B3 +: 8] << HI_SHIFT)
                                    + st.dec_word[B2 +: 8];
        next_st.dec_err           = st.dec_word[B2 +: 8] == invalid_code_marker
                                    || st.dec_word[B3 +: 8] == invalid_code_marker;
        next_st.dec_out_valid     = 1'b1;
        next_st.dstate            = DEC_IDLE;
      end
      default: begin
        next_st.dstate = DEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st        <= '0;
      st.dstate <= DEC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // one fixed variant cannot track running disparity, so balance and run
  // length hold only per group, not across a long stream
  assign enc_sym       = {st.enc_word[B3 +: SIX_W], st.enc_word[B2 +: FOUR_W]};
  assign enc_out_valid = st.enc_out_valid;
  assign dec_out_valid = st.dec_out_valid;
  assign dec_byte      = st.dec_word[B0 +: 8];
  assign dec_err       = st.dec_err;

  a_enc_one_symbol: assert property (@(posedge ref_clk) disable iff (rst)
    enc_take |=> enc_out_valid)
    else $error("encoder gave no symbol one cycle after a byte");
  a_enc_low_map: assert property (@(posedge ref_clk) disable iff (rst)
    enc_take |=> enc_sym[SYM_W-1:FOUR_W] == $past(enc6_q[SIX_W-1:0]))
    else $error("six-bit group differs from the low table entry");
  a_enc_high_map: assert property (@(posedge ref_clk) disable iff (rst)
    enc_take |=> enc_sym[FOUR_W-1:0] == $past(enc4_q[FOUR_W-1:0]))
    else $error("four-bit group differs from the high table entry");
  a_enc_raw_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    enc_take |=> st.enc_word[B0 +: 8] == {3'h0, $past(enc_byte[4:0])}
                 && st.enc_word[B1 +: 8] == {5'h0, $past(enc_byte[7:5])})
    else $error("raw byte parts not in encode word bytes 0 and 1");
  a_dec_two_step: assert property (@(posedge ref_clk) disable iff (rst)
    dec_take |=> !dec_in_ready ##1 !dec_out_valid ##1 dec_out_valid)
    else $error("decoder did not answer three cycles after a symbol");
  a_dec_rx_lanes: assert property (@(posedge ref_clk) disable iff (rst)
    dec_take |=> st.dec_word[B1 +: 8] == {2'h0, $past(dec_sym[9:4])}
                 && st.dec_word[B0 +: 8] == {4'h0, $past(dec_sym[3:0])})
    else $error("received groups not in decode word bytes 1 and 0");
  a_dec_combine: assert property (@(posedge ref_clk) disable iff (rst)
    dec_out_valid |-> dec_byte == 8'({$past(st.dec_word[B3 +: 3]), 5'h00}
                                     + $past(st.dec_word[B2 +: 8])))
    else $error("decoded byte is not high part shifted by five plus low part");
  a_dec_marker_err: assert property (@(posedge ref_clk) disable iff (rst)
    dec_out_valid |-> dec_err == ($past(st.dec_word[B2 +: 8]) == invalid_code_marker
                                  || $past(st.dec_word[B3 +: 8]) == invalid_code_marker))
    else $error("code error flag does not match the invalid marker");
  a_dec_roundtrip: assert property (@(posedge ref_clk) disable iff (rst)
    dec_take && $past(enc_out_valid) && dec_sym == $past(enc_sym) && !tbl_wr
    |-> ##3 !dec_err)
    else $error("decoding a freshly encoded symbol raised a code error");
endmodule : eightb_tenb_lut_codec

// >>> rtl/lut_table.sv
// flip-flop lookup table with reset contents, one write port, one combinational read
`timescale 1ns/1ps
module lut_table #(
  parameter int                                 ADDR_W = 5,
  parameter int                                 DATA_W = 8,
  parameter logic [(2**ADDR_W)*DATA_W-1:0]      INIT   = '0
) (
  input  wire logic               ref_clk, // core clock
  input  wire logic               rst,     // synchronous reset reloads INIT
  input  wire logic               wr_en,   // entry write strobe
  input  wire logic [ADDR_W-1:0]  wr_addr, // entry written
  input  wire logic [DATA_W-1:0]  wr_data, // value written
  input  wire logic [ADDR_W-1:0]  rd_addr, // entry read
  output logic [DATA_W-1:0]       rd_data  // value read, same cycle
);
  typedef struct packed {
    logic [(2**ADDR_W)-1:0][DATA_W-1:0] mem;
  } table_t;

  table_t st;
  table_t next_st;

  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.mem[wr_addr] = wr_data;
    end
  end

  // reset value is a constant, so it stays legal under any reset style
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= table_t'(INIT);
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.mem[rd_addr];

  a_write_lands: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en |=> st.mem[$past(wr_addr)] == $past(wr_data))
    else $error("table write did not land in the addressed entry");
endmodule : lut_table

// >>> sim/eightb_tenb_lut_codec_tb.sv
// self-checking bench of the table-driven 8b/10b codec
`timescale 1ns/1ps
module eightb_tenb_lut_codec_tb;
  import codec_pkg::*;
  typedef struct packed {
    logic [7:0] b;
    logic [9:0] s;
  } row_t;
  localparam row_t ROWS [8] = '{'{8'h00, 10'h184}, '{8'h34, 10'h0b9}, '{8'hff, 10'h141},
    '{8'ha5, 10'h29a}, '{8'h5a, 10'h165}, '{8'h07, 10'h074}, '{8'he3, 10'h311},
    '{8'h1c, 10'h0e4}};
  logic              ref_clk;
  logic              rst;
  logic              tbl_wr;
  logic [SEL_W-1:0]  tbl_sel;
  logic [ADDR_W-1:0] tbl_addr;
  logic [ENT_W-1:0]  tbl_data;
  logic              enc_in_valid;
  logic              enc_in_ready;
  logic [7:0]        enc_byte;
  logic              enc_out_valid;
  logic [SYM_W-1:0]  enc_sym;
  logic              dec_in_valid;
  logic              dec_in_ready;
  logic [SYM_W-1:0]  dec_sym;
  logic              dec_out_valid;
  logic [7:0]        dec_byte;
  logic              dec_err;
  logic              inj_valid;
  logic [9:0]        inj_sym;
  logic              slow;
  logic [8:0]        exp_q [$];
  logic [8:0]        e;
  int                err_total = 0;
  int                checks = 0;

  eightb_tenb_lut_codec dut (.ref_clk(ref_clk), .rst(rst), .tbl_wr(tbl_wr), .tbl_sel(tbl_sel),
    .tbl_addr(tbl_addr), .tbl_data(tbl_data), .enc_in_valid(enc_in_valid),
    .enc_in_ready(enc_in_ready), .enc_byte(enc_byte), .enc_out_valid(enc_out_valid),
    .enc_sym(enc_sym), .dec_in_valid(dec_in_valid), .dec_in_ready(dec_in_ready),
    .dec_sym(dec_sym), .dec_out_valid(dec_out_valid), .dec_byte(dec_byte), .dec_err(dec_err));
  line_partner line (.ref_clk(ref_clk), .enc_out_valid(enc_out_valid), .enc_sym(enc_sym),
    .inj_valid(inj_valid), .inj_sym(inj_sym), .slow(slow), .dec_in_ready(dec_in_ready),
    .dec_in_valid(dec_in_valid), .dec_sym(dec_sym));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic fail(input string msg);
    err_total++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail
  task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("symbol %h expected %h", got, exp));
  endtask : chk10
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail($sformatf("flag %b expected %b", got, exp));
  endtask : chk1
  task automatic test_done();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // every decoder output is matched against the queue of expected results, the byte only when no error is expected
  always @(negedge ref_clk) begin
    if (!rst && dec_out_valid === 1'b1) begin
      if (exp_q.size() == 0) fail("byte with nothing pending");
      else begin
        e = exp_q.pop_front();
        chk1(dec_err, e[8]);
        if (!e[8]) chk8(dec_byte, e[7:0]);
      end
    end
  end

  // back to back bytes, result checked one cycle after each take
  task automatic run_rows();
    for (int i = 0; i <= 8; i++) begin
      @(negedge ref_clk);
      if (i > 0) chk1(enc_out_valid, 1'b1);
      if (i > 0) chk10(enc_sym, ROWS[i-1].s);
      enc_in_valid = (i < 8);
      if (i < 8) begin
        enc_byte = ROWS[i].b;
        exp_q.push_back({1'b0, ROWS[i].b});
      end
    end
    @(negedge ref_clk);
    chk1(enc_out_valid, 1'b0);
  endtask : run_rows
  task automatic drain();
    for (int n = 0; n < 200 && exp_q.size() > 0; n++) @(negedge ref_clk);
    chk1(exp_q.size() == 0, 1'b1);
  endtask : drain

  initial begin
    #(8ns * 3000);
    fail("watchdog expired");
    test_done();
  end

  initial begin
    rst = 1'b1; tbl_wr = 1'b0; tbl_sel = '0; tbl_addr = '0; tbl_data = '0;
    enc_in_valid = 1'b0; enc_byte = 8'h00; inj_valid = 1'b0; inj_sym = 10'h000; slow = 1'b0;
    repeat (20) @(negedge ref_clk);
    chk1(enc_out_valid, 1'b0);
    chk10(enc_sym, 10'h000);
    chk8(dec_byte, 8'h00);
    chk1(enc_in_ready, 1'b1);
    chk1(dec_out_valid, 1'b0);
    chk1(dec_err, 1'b0);
    chk1(dec_in_ready, 1'b1);
    rst = 1'b0;
    run_rows();
    drain();
    slow = 1'b1; // decoder idles between offers
    run_rows();
    drain();
    slow = 1'b0;
    // complemented groups decode, an all-zero group is invalid
    @(negedge ref_clk);
    inj_valid = 1'b1; inj_sym = 10'h27b; exp_q.push_back(9'h000);
    @(negedge ref_clk);
    inj_sym = 10'h000; exp_q.push_back(9'h100);
    @(negedge ref_clk);
    inj_valid = 1'b0;
    drain();
    // table writes refuse the encoder, then new entries take effect
    @(negedge ref_clk);
    tbl_wr = 1'b1; tbl_sel = SEL_DEC5; tbl_addr = 6'h3f; tbl_data = 8'h11;
    @(negedge ref_clk);
    tbl_sel = SEL_DEC3; tbl_addr = 6'h04; tbl_data = 8'h02; enc_in_valid = 1'b1; enc_byte = 8'h00;
    #1 chk1(enc_in_ready, 1'b0);
    chk1(dec_in_ready, 1'b0);
    @(negedge ref_clk);
    chk1(enc_out_valid, 1'b0);
    tbl_sel = SEL_ENC6; tbl_addr = 6'h00; tbl_data = 8'h3f;
    @(negedge ref_clk);
    chk1(enc_out_valid, 1'b0);
    tbl_wr = 1'b0; exp_q.push_back(9'h051);
    @(negedge ref_clk);
    enc_in_valid = 1'b0;
    chk1(enc_out_valid, 1'b1);
    chk10(enc_sym, 10'h3f4);
    drain();
    // reset mid-run restores standard contents
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk10(enc_sym, 10'h000);
    chk1(enc_out_valid, 1'b0);
    rst = 1'b0; enc_in_valid = 1'b1; exp_q.push_back(9'h000);
    @(negedge ref_clk);
    enc_in_valid = 1'b0;
    chk10(enc_sym, 10'h184);
    drain();
    test_done();
  end
endmodule : eightb_tenb_lut_codec_tb

// >>> sim/line_partner.sv
// far-side model: loops encoded symbols back to the decoder, plus injected symbols
`timescale 1ns/1ps
module line_partner (
  input  wire logic        ref_clk,       // core clock
  input  wire logic        enc_out_valid, // symbol pulse from the encoder
  input  wire logic [9:0]  enc_sym,       // encoded symbol
  input  wire logic        inj_valid,     // extra symbol from the bench
  input  wire logic [9:0]  inj_sym,       // extra symbol value
  input  wire logic        slow,          // wait four cycles between offers
  input  wire logic        dec_in_ready,  // decoder takes the symbol
  output logic             dec_in_valid,  // symbol offered
  output logic [9:0]       dec_sym        // offered symbol
);
  logic [9:0] q [$];
  logic       taken;
  int         wait_n;
  initial begin
    dec_in_valid = 1'b0;
    dec_sym      = 10'h000;
    taken        = 1'b0;
    wait_n       = 0;
  end
  always @(posedge ref_clk) begin
    taken <= dec_in_valid && dec_in_ready;
    if (enc_out_valid === 1'b1) q.push_back(enc_sym);
    if (inj_valid) q.push_back(inj_sym);
  end
  // offers change only after a falling edge and hold until a taking edge
  always @(negedge ref_clk) begin
    if (taken) begin
      void'(q.pop_front());
      dec_in_valid = 1'b0;
      dec_sym      = ~dec_sym; // released line shows no stale symbol
      wait_n       = slow ? 4 : 0;
    end else if (!dec_in_valid) begin
      if (wait_n > 0) wait_n--;
      else if (q.size() > 0) begin
        dec_sym      = q[0];
        dec_in_valid = 1'b1;
      end else dec_sym = ~dec_sym;
    end
  end
endmodule : line_partner
